// >>> fat_frame_timing.sv
`timescale 1ns/1ps
`default_nettype none
module fat_frame_timing import fat_pkg::*; #(
  parameter int unsigned VARIANT = 0,
  parameter int unsigned START_DELAY_CYC = fat_ceil_cyc(START_DELAY_NS[VARIANT]),
  parameter int unsigned LINE_CYC = fat_ceil_cyc(LINE_READOUT_NS[VARIANT]),
  parameter int unsigned FIXED_CYC = fat_ceil_cyc(FIXED_READOUT_NS[VARIANT]),
  parameter int unsigned OVERHEAD_CYC = fat_ceil_cyc(EXPOSURE_OVERHEAD_NS[VARIANT])
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic external_trigger_input,
  output logic acq_begin_notice,
  output logic frame_begin_notice,
  output logic exposure_done_notice,
  output logic frame_tx_start,
  output logic frame_tx_active,
  output logic irq
);
  fat_cfg_t cfg_ff;
  logic [31:0] debounce_ff, exposure_ff, height_ff, throughput_ff, payload_ff;
  logic [4:0] avg_shift_ff;
  logic [31:0] tx_thresh_ff;
  logic [NUM_EVT-1:0] evt_status_ff, evt_mask_ff, evt_set;
  logic acq_start_cmd_ff, acq_stop_cmd_ff;
  logic stop_pend_ff;
  logic wr_pend_ff, rd_pend_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic trig_prev_ff;
  fat_state_t state_ff, nxt_state;
  logic [31:0] timer_ff, nxt_timer;
  logic [31:0] rd_elapsed_ff;
  logic [31:0] readout_cyc_ff, tx_cyc_ff, tx_lim_ff, min_period_ff;
  logic [31:0] avg_cnt_ff;
  logic tx_pend_ff, tx_active_ff, tx_start_ff;
  logic [31:0] tx_cnt_ff;
  logic acq_evt_ff, frame_evt_ff, exp_evt_ff;
  logic div_busy_ff;
  logic [6:0] div_step_ff;
  logic [63:0] div_q_ff, div_r_ff;
  logic [31:0] div_pay_ff, div_thr_ff;

  logic addr_phase, trig_edge, acq_req, overtrig, frame_go, exp_end, rd_done;
  logic avg_last, tx_req, tx_go, tx_end;
  logic [31:0] start_delay, tx_dur, nxt_readout, exp_lim;
  logic [64:0] div_trial;

  assign addr_phase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign trig_edge = external_trigger_input & ~trig_prev_ff;

  assign acq_req = cfg_ff.legacy ? trig_edge : acq_start_cmd_ff;
  assign overtrig = acq_req & (state_ff != S_IDLE);
  assign frame_go = cfg_ff.legacy ? (acq_req & ~overtrig)
                                  : (trig_edge & (state_ff == S_ARMED));
  assign start_delay = START_DELAY_CYC + (cfg_ff.deb_en ? debounce_ff : 32'h0);
  assign exp_end = (state_ff == S_EXPOSE) & (timer_ff == 32'h0);
  assign rd_done = (state_ff == S_READOUT) & (rd_elapsed_ff + 32'h1 >= readout_cyc_ff);
  assign avg_last = (avg_cnt_ff + 32'h1) >= (32'h1 << avg_shift_ff);
  // averaging sends one image
  // a threshold beyond the end of readout falls back to the last readout cycle
  assign tx_req = cfg_ff.avg_en ? (rd_done & avg_last)
      : ((state_ff == S_READOUT) & ((rd_elapsed_ff == tx_thresh_ff)
          | (rd_done & (rd_elapsed_ff < tx_thresh_ff))));
  // start waits on buffer and link, not a fixed count
  assign tx_go = (tx_req | tx_pend_ff) & ~tx_active_ff;
  assign tx_end = tx_active_ff & (tx_cnt_ff == 32'h0);
  assign tx_dur = (tx_cyc_ff > readout_cyc_ff) ? tx_cyc_ff : readout_cyc_ff;
  assign nxt_readout = 32'((height_ff + 32'h1) * LINE_CYC + FIXED_CYC);
  assign exp_lim = exposure_ff + OVERHEAD_CYC;
  assign div_trial = {div_r_ff, div_q_ff[63]} - {33'h0, div_thr_ff};

  always_comb begin
    evt_set = '0;
    evt_set[EVT_ACQ] = acq_req & ~overtrig;
    evt_set[EVT_FRAME] = frame_go;
    evt_set[EVT_EXP_END] = exp_end;
    evt_set[EVT_OVERTRIG] = overtrig;
    evt_set[EVT_TX_DONE] = tx_end;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff <= 8'h0;
    end else begin
      wr_pend_ff <= addr_phase & hwrite;
      rd_pend_ff <= addr_phase & ~hwrite;
      addr_ff <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_ff <= '0;
      debounce_ff <= 32'h0;
      exposure_ff <= RST_EXPOSURE;
      height_ff <= RST_HEIGHT;
      throughput_ff <= RST_THROUGHPUT;
      payload_ff <= RST_PAYLOAD;
      avg_shift_ff <= 5'h0;
      tx_thresh_ff <= RST_TX_THRESH;
      evt_mask_ff <= '0;
      acq_start_cmd_ff <= 1'b0;
      acq_stop_cmd_ff <= 1'b0;
    end else begin
      acq_start_cmd_ff <= 1'b0;
      acq_stop_cmd_ff <= 1'b0;
      if (wr_pend_ff) begin
        case (addr_ff)
          ADDR_CTRL: begin
            cfg_ff.legacy <= hwdata[CTRL_LEGACY];
            cfg_ff.deb_en <= hwdata[CTRL_DEB_EN];
            cfg_ff.avg_en <= hwdata[CTRL_AVG_EN];
            cfg_ff.single <= hwdata[CTRL_SINGLE];
            acq_start_cmd_ff <= hwdata[CTRL_ACQ_START];
            acq_stop_cmd_ff <= hwdata[CTRL_ACQ_STOP];
          end
          ADDR_DEBOUNCE: debounce_ff <= hwdata;
          ADDR_EXPOSURE: exposure_ff <= (hwdata == 32'h0) ? 32'h1 : hwdata;
          ADDR_HEIGHT: height_ff <= hwdata;
          ADDR_THROUGHPUT: throughput_ff <= hwdata;
          ADDR_PAYLOAD: payload_ff <= hwdata;
          ADDR_AVG_SHIFT: avg_shift_ff <= hwdata[4:0];
          ADDR_TX_THRESH: tx_thresh_ff <= hwdata;
          ADDR_EVT_MASK: evt_mask_ff <= hwdata[NUM_EVT-1:0];
          default: ;
        endcase
      end
    end
  end

  // read data is loaded at the address edge so the data phase needs no wait
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0;
    end else if (addr_phase & ~hwrite) begin
      case (haddr[7:0])
        ADDR_CTRL: hrdata_ff <= {28'h0, cfg_ff.single, cfg_ff.avg_en, cfg_ff.deb_en,
                                 cfg_ff.legacy};
        ADDR_DEBOUNCE: hrdata_ff <= debounce_ff;
        ADDR_EXPOSURE: hrdata_ff <= exposure_ff;
        ADDR_HEIGHT: hrdata_ff <= height_ff;
        ADDR_THROUGHPUT: hrdata_ff <= throughput_ff;
        ADDR_PAYLOAD: hrdata_ff <= payload_ff;
        ADDR_AVG_SHIFT: hrdata_ff <= {27'h0, avg_shift_ff};
        ADDR_TX_THRESH: hrdata_ff <= tx_thresh_ff;
        ADDR_EVT_STATUS: hrdata_ff <= {{(32-NUM_EVT){1'b0}}, evt_status_ff};
        ADDR_EVT_MASK: hrdata_ff <= {{(32-NUM_EVT){1'b0}}, evt_mask_ff};
        ADDR_STATE: hrdata_ff <= {27'h0, tx_pend_ff, tx_active_ff, state_ff};
        ADDR_READOUT_CYC: hrdata_ff <= readout_cyc_ff;
        ADDR_MIN_PERIOD: hrdata_ff <= min_period_ff;
        ADDR_TX_CYC: hrdata_ff <= tx_cyc_ff;
        default: hrdata_ff <= 32'h0;
      endcase
    end
  end

  // read clears status; a new event in the same cycle survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_status_ff <= '0;
    end else if (addr_phase & ~hwrite & (haddr[7:0] == ADDR_EVT_STATUS)) begin
      evt_status_ff <= evt_set;
    end else begin
      evt_status_ff <= evt_status_ff | evt_set;
    end
  end

  assign irq = |(evt_status_ff & evt_mask_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trig_prev_ff <= 1'b0;
      acq_evt_ff <= 1'b0;
      frame_evt_ff <= 1'b0;
      exp_evt_ff <= 1'b0;
    end else begin
      trig_prev_ff <= external_trigger_input;
      acq_evt_ff <= evt_set[EVT_ACQ];
      frame_evt_ff <= evt_set[EVT_FRAME];
      exp_evt_ff <= evt_set[EVT_EXP_END];
    end
  end

  assign acq_begin_notice = acq_evt_ff;
  assign frame_begin_notice = frame_evt_ff;
  assign exposure_done_notice = exp_evt_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_timer = (timer_ff == 32'h0) ? 32'h0 : timer_ff - 32'h1;
    case (state_ff)
      S_IDLE: begin
        if (frame_go) begin
          nxt_state = S_DELAY;
          nxt_timer = start_delay - 32'h1;
        end else if (acq_req & ~cfg_ff.legacy) begin
          nxt_state = S_ARMED;
        end
      end
      S_ARMED: begin
        if (acq_stop_cmd_ff | stop_pend_ff) begin
          nxt_state = S_IDLE;
        end else if (frame_go) begin
          nxt_state = S_DELAY;
          nxt_timer = start_delay - 32'h1;
        end
      end
      S_DELAY: begin
        if (timer_ff == 32'h0) begin
          nxt_state = S_EXPOSE;
          nxt_timer = exposure_ff - 32'h1;
        end
      end
      S_EXPOSE: begin
        if (exp_end) begin
          nxt_state = S_READOUT;
        end
      end
      S_READOUT: begin
        if (rd_done) begin
          nxt_state = (cfg_ff.legacy | cfg_ff.single | acq_stop_cmd_ff | stop_pend_ff)
                      ? S_IDLE : S_ARMED;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= S_IDLE;
      timer_ff <= 32'h0;
      rd_elapsed_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      rd_elapsed_ff <= (state_ff == S_READOUT) ? rd_elapsed_ff + 32'h1 : 32'h0;
    end
  end

  // a stop that lands mid-frame is held, otherwise its one-cycle pulse is lost
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_pend_ff <= 1'b0;
    end else if (state_ff == S_IDLE) begin
      stop_pend_ff <= 1'b0;
    end else if (acq_stop_cmd_ff) begin
      stop_pend_ff <= 1'b1;
    end
  end

  // frame counter for averaging; reset when averaging is off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      avg_cnt_ff <= 32'h0;
    end else if (~cfg_ff.avg_en) begin
      avg_cnt_ff <= 32'h0;
    end else if (rd_done) begin
      avg_cnt_ff <= avg_last ? 32'h0 : avg_cnt_ff + 32'h1;
    end
  end

  // one frame may wait while the previous transmission still runs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_pend_ff <= 1'b0;
      tx_active_ff <= 1'b0;
      tx_start_ff <= 1'b0;
      tx_cnt_ff <= 32'h0;
    end else begin
      tx_start_ff <= tx_go;
      if (tx_go) begin
        tx_pend_ff <= 1'b0;
      end else if (tx_req) begin
        tx_pend_ff <= 1'b1;
      end
      if (tx_go) begin
        tx_active_ff <= 1'b1;
        tx_cnt_ff <= tx_dur - 32'h1;
      end else if (tx_end) begin
        tx_active_ff <= 1'b0;
      end else if (tx_active_ff) begin
        tx_cnt_ff <= tx_cnt_ff - 32'h1;
      end
    end
  end

  assign frame_tx_start = tx_start_ff;
  assign frame_tx_active = tx_active_ff;

  // payload times rate over throughput, serial divide
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_busy_ff <= 1'b0;
      div_step_ff <= 7'h0;
      div_q_ff <= 64'h0;
      div_r_ff <= 64'h0;
      div_pay_ff <= 32'h0;
      div_thr_ff <= 32'h0;
      tx_cyc_ff <= 32'hffffffff;
    end else if (~div_busy_ff) begin
      if ((div_pay_ff != payload_ff) | (div_thr_ff != throughput_ff)) begin
        div_busy_ff <= 1'b1;
        div_step_ff <= 7'h0;
        div_pay_ff <= payload_ff;
        div_thr_ff <= throughput_ff;
        div_q_ff <= 64'(payload_ff) * 64'(CLK_HZ);
        div_r_ff <= 64'h0;
      end
    end else if (div_step_ff == 7'(DIV_STEPS)) begin
      div_busy_ff <= 1'b0;
      // rounded up; zero throughput pins the limit at the maximum
      if ((div_thr_ff == 32'h0) | (|div_q_ff[63:32])) begin
        tx_cyc_ff <= 32'hffffffff;
      end else begin
        tx_cyc_ff <= div_q_ff[31:0] + {31'h0, |div_r_ff};
      end
    end else begin
      div_step_ff <= div_step_ff + 7'h1;
      if (~div_trial[64]) begin
        div_r_ff <= div_trial[63:0];
        div_q_ff <= {div_q_ff[62:0], 1'b1};
      end else begin
        div_r_ff <= {div_r_ff[62:0], div_q_ff[63]};
        div_q_ff <= {div_q_ff[62:0], 1'b0};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      readout_cyc_ff <= 32'h0;
      tx_lim_ff <= 32'h0;
      min_period_ff <= 32'h0;
    end else begin
      readout_cyc_ff <= nxt_readout;
      // averaging limit, link shared by averaged frames
      tx_lim_ff <= cfg_ff.avg_en ? (tx_cyc_ff >> avg_shift_ff) : tx_cyc_ff;
      if ((readout_cyc_ff >= exp_lim) & (readout_cyc_ff >= tx_lim_ff)) begin
        min_period_ff <= readout_cyc_ff;
      end else if (exp_lim >= tx_lim_ff) begin
        min_period_ff <= exp_lim;
      end else begin
        min_period_ff <= tx_lim_ff;
      end
    end
  end
endmodule : fat_frame_timing
`default_nettype wire

// >>> fat_frame_timing_sva.sv
`timescale 1ns/1ps
`default_nettype none
module fat_frame_timing_sva #(
  parameter int unsigned START_DELAY_CYC = 20,
  parameter int unsigned LINE_CYC = 5,
  parameter int unsigned FIXED_CYC = 30
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic external_trigger_input,
  input wire logic acq_begin_notice,
  input wire logic frame_begin_notice,
  input wire logic exposure_done_notice,
  input wire logic frame_tx_start,
  input wire logic frame_tx_active
);
  logic [31:0] since_fr_ff;
  logic [31:0] act_len_ff;
  logic in_frame_ff;
  // saturates so a long idle never wraps into a false short delay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) since_fr_ff <= 32'h0;
    else if (frame_begin_notice) since_fr_ff <= 32'h1;
    else if (since_fr_ff != 32'hffffffff) since_fr_ff <= since_fr_ff + 32'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) act_len_ff <= 32'h0;
    else act_len_ff <= frame_tx_active ? act_len_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) in_frame_ff <= 1'b0;
    else if (frame_begin_notice) in_frame_ff <= 1'b1;
    else if (exposure_done_notice) in_frame_ff <= 1'b0;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence one_shot_s(s);
    s ##1 !s;
  endsequence
  acq_pulse_a: assert property (acq_begin_notice |-> one_shot_s(acq_begin_notice))
    else $error("acq notice longer than one cycle");
  frame_pulse_a: assert property (frame_begin_notice |-> one_shot_s(frame_begin_notice))
    else $error("frame notice longer than one cycle");
  exp_pulse_a: assert property (exposure_done_notice |-> one_shot_s(exposure_done_notice))
    else $error("exposure notice longer than one cycle");
  frame_edge_a: assert property (frame_begin_notice |->
    $past(external_trigger_input) && !$past(external_trigger_input, 2))
    else $error("frame notice without a trigger rise");
  // exposure can never end before the start delay has run
  start_delay_a: assert property (exposure_done_notice |-> since_fr_ff >= START_DELAY_CYC)
    else $error("exposure ended inside the start delay");
  exp_in_frame_a: assert property (exposure_done_notice |-> in_frame_ff)
    else $error("exposure end without a frame start");
  tx_launch_a: assert property (frame_tx_start |-> ##[0:1] frame_tx_active)
    else $error("transmit start without active transfer");
  tx_first_a: assert property ($rose(frame_tx_active) |-> frame_tx_start || $past(frame_tx_start))
    else $error("transfer active without a start");
  tx_start_pulse_a: assert property (frame_tx_start |-> one_shot_s(frame_tx_start))
    else $error("transmit start longer than one cycle");
  tx_pace_a: assert property ($fell(frame_tx_active) |-> act_len_ff >= LINE_CYC + FIXED_CYC)
    else $error("transfer shorter than shortest readout");
endmodule : fat_frame_timing_sva
bind fat_frame_timing fat_frame_timing_sva #(
  .START_DELAY_CYC(START_DELAY_CYC),
  .LINE_CYC(LINE_CYC),
  .FIXED_CYC(FIXED_CYC)
) chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .external_trigger_input(external_trigger_input),
  .acq_begin_notice(acq_begin_notice),
  .frame_begin_notice(frame_begin_notice),
  .exposure_done_notice(exposure_done_notice),
  .frame_tx_start(frame_tx_start),
  .frame_tx_active(frame_tx_active)
);
`default_nettype wire

// >>> fat_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fat_host_rx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic frame_tx_active,
  output logic [31:0] n_frames,
  output logic [31:0] last_len
);
  logic [31:0] cur_ff;
  // a frame counts only once its transfer has ended
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cur_ff <= 32'h0;
      n_frames <= 32'h0;
      last_len <= 32'h0;
    end else if (frame_tx_active) begin
      cur_ff <= cur_ff + 32'h1;
    end else if (cur_ff != 32'h0) begin
      last_len <= cur_ff;
      n_frames <= n_frames + 32'h1;
      cur_ff <= 32'h0;
    end
  end
endmodule : fat_host_rx
`default_nettype wire

// >>> fat_pkg.sv
package fat_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned NUM_VARIANTS = 5;
  typedef int unsigned fat_ns_tbl_t [NUM_VARIANTS];
  localparam fat_ns_tbl_t START_DELAY_NS = '{23640, 48780, 40130, 65980, 32060};
  localparam fat_ns_tbl_t LINE_READOUT_NS = '{8760, 13390, 12920, 19560, 20940};
  localparam fat_ns_tbl_t FIXED_READOUT_NS = '{511570, 7403210, 3627580, 4756520, 15385070};
  localparam fat_ns_tbl_t EXPOSURE_OVERHEAD_NS = '{30000, 62000, 59000, 61000, 37000};

  function automatic int unsigned fat_ceil_cyc(input int unsigned ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : fat_ceil_cyc

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h04;
  localparam logic [7:0] ADDR_EXPOSURE = 8'h08;
  localparam logic [7:0] ADDR_HEIGHT = 8'h0c;
  localparam logic [7:0] ADDR_THROUGHPUT = 8'h10;
  localparam logic [7:0] ADDR_PAYLOAD = 8'h14;
  localparam logic [7:0] ADDR_AVG_SHIFT = 8'h18;
  localparam logic [7:0] ADDR_TX_THRESH = 8'h1c;
  localparam logic [7:0] ADDR_EVT_STATUS = 8'h20;
  localparam logic [7:0] ADDR_EVT_MASK = 8'h24;
  localparam logic [7:0] ADDR_STATE = 8'h28;
  localparam logic [7:0] ADDR_READOUT_CYC = 8'h2c;
  localparam logic [7:0] ADDR_MIN_PERIOD = 8'h30;
  localparam logic [7:0] ADDR_TX_CYC = 8'h34;

  localparam int unsigned CTRL_LEGACY = 0;
  localparam int unsigned CTRL_DEB_EN = 1;
  localparam int unsigned CTRL_AVG_EN = 2;
  localparam int unsigned CTRL_SINGLE = 3;
  localparam int unsigned CTRL_ACQ_START = 4;
  localparam int unsigned CTRL_ACQ_STOP = 5;

  localparam int unsigned NUM_EVT = 5;
  localparam int unsigned EVT_ACQ = 0;
  localparam int unsigned EVT_FRAME = 1;
  localparam int unsigned EVT_EXP_END = 2;
  localparam int unsigned EVT_OVERTRIG = 3;
  localparam int unsigned EVT_TX_DONE = 4;

  localparam logic [31:0] RST_EXPOSURE = 32'h000003e8;
  localparam logic [31:0] RST_HEIGHT = 32'h00000190;
  localparam logic [31:0] RST_THROUGHPUT = 32'h068e7780;
  localparam logic [31:0] RST_PAYLOAD = 32'h0003a980;
  localparam logic [31:0] RST_TX_THRESH = 32'h00000100;
  localparam int unsigned DIV_STEPS = 64;

  typedef struct packed {
    logic legacy;
    logic deb_en;
    logic avg_en;
    logic single;
  } fat_cfg_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ARMED = 3'b001,
    S_DELAY = 3'b010,
    S_EXPOSE = 3'b011,
    S_READOUT = 3'b100
  } fat_state_t;
endpackage : fat_pkg

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb import fat_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, external_trigger_input;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hready;
  logic hreadyout, hresp, acq_begin_notice, frame_begin_notice, exposure_done_notice;
  logic frame_tx_start, frame_tx_active, irq;
  int mismatches, comparisons;
  logic [31:0] n_tx, tx_len, cyc, t_fr, t_ex, t_acq, n_acq, n_fr, t0, c_acq, c_fr;
  assign hready = hreadyout;
  fat_frame_timing #(.START_DELAY_CYC(20), .LINE_CYC(5), .FIXED_CYC(30), .OVERHEAD_CYC(10)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .external_trigger_input, .acq_begin_notice, .frame_begin_notice,
    .exposure_done_notice, .frame_tx_start, .frame_tx_active, .irq);
  fat_host_rx host (.hclk, .hresetn, .frame_tx_active, .n_frames(n_tx), .last_len(tx_len));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 32'h1;
    if (acq_begin_notice) begin
      n_acq <= n_acq + 32'h1;
      t_acq <= cyc;
    end
    if (frame_begin_notice) begin
      n_fr <= n_fr + 32'h1;
      t_fr <= cyc;
    end
    if (exposure_done_notice) t_ex <= cyc;
  end
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(a, 1'b1, d, x);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(a, 1'b0, 32'h0, d);
    `CHK(nm, e, d)
  endtask : rd_chk
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle
  task automatic pulse;
    @(posedge hclk);
    external_trigger_input <= 1'b1;
    repeat (3) @(posedge hclk);
    external_trigger_input <= 1'b0;
  endtask : pulse
  // bounded wait, the readout to transmit gap is not a fixed count
  task automatic wait_tx(input logic [31:0] n);
    for (int i = 0; i < 3000; i++) begin
      if (n_tx === n) break;
      @(posedge hclk);
    end
    `CHK("frames_sent", n, n_tx)
  endtask : wait_tx
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    conclude();
  end
  initial begin
    {hresetn, hsel, hwrite, external_trigger_input, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {cyc, t_fr, t_ex, t_acq, n_acq, n_fr} = '0;
    mismatches = 0;
    comparisons = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("height_rst", ADDR_HEIGHT, RST_HEIGHT);
    rd_chk("unmapped", 8'hfc, 32'h0);
    wr(ADDR_HEIGHT, 32'h3);
    wr(ADDR_EXPOSURE, 32'h8);
    wr(ADDR_PAYLOAD, 32'h14);
    wr(ADDR_THROUGHPUT, 32'h05f5e100);
    wr(ADDR_TX_THRESH, 32'ha);
    settle(200);
    rd_chk("readout_cyc", ADDR_READOUT_CYC, 32'h32);
    rd_chk("tx_cyc", ADDR_TX_CYC, 32'h14);
    rd_chk("min_period", ADDR_MIN_PERIOD, 32'h32);
    wr(ADDR_EXPOSURE, 32'h64);
    settle(3);
    rd_chk("min_period_exp", ADDR_MIN_PERIOD, 32'h6e);
    wr(ADDR_EXPOSURE, 32'h8);
    wr(ADDR_CTRL, 32'h18);
    pulse();
    wait_tx(32'h1);
    t0 = t_ex - t_fr;
    `CHK("exp_start", 1'b1, (t0 - 32'd28) <= 32'd1)
    `CHK("tx_len", 32'h32, tx_len)
    rd_chk("status", ADDR_EVT_STATUS, 32'h17);
    rd_chk("status_clr", ADDR_EVT_STATUS, 32'h0);
    pulse();
    settle(60);
    rd_chk("idle_trig", ADDR_EVT_STATUS, 32'h0);
    wr(ADDR_DEBOUNCE, 32'h7);
    wr(ADDR_EVT_MASK, 32'h8);
    wr(ADDR_CTRL, 32'h1a);
    pulse();
    wr(ADDR_CTRL, 32'h1a);
    settle(1);
    `CHK("irq_set", 1'b1, irq)
    rd_chk("overtrig", ADDR_EVT_STATUS, 32'h0b);
    settle(1);
    `CHK("irq_clr", 1'b0, irq)
    wait_tx(32'h2);
    `CHK("debounce", t0 + 32'h7, t_ex - t_fr)
    c_acq = n_acq;
    c_fr = n_fr;
    wr(ADDR_TX_THRESH, 32'h40);
    wr(ADDR_CTRL, 32'h1);
    pulse();
    wait_tx(32'h3);
    `CHK("legacy_acq", c_acq + 32'h1, n_acq)
    `CHK("legacy_frame", c_fr + 32'h1, n_fr)
    `CHK("legacy_same", t_acq, t_fr)
    wr(ADDR_AVG_SHIFT, 32'h1);
    wr(ADDR_CTRL, 32'h14);
    pulse();
    settle(150);
    `CHK("avg_hold", 32'h3, n_tx)
    pulse();
    wait_tx(32'h4);
    settle(150);
    `CHK("avg_once", 32'h4, n_tx)
    wr(ADDR_CTRL, 32'h20);
    conclude();
  end
endmodule : tb
`default_nettype wire
